// *** hdl/cpf_codec_port.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------
module cpf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("cpf_fifo: DEPTH must be a power of two of at least 2");
  end

  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;
  assign o_rd_valid = (count != '0);
  assign o_rd_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_wr_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      // Registered so the ready pin comes straight from a flop
      o_wr_ready <= (next_count < (AW+1)'(DEPTH));
    end
  end
endmodule

// ----------------------------------------------------------------
// Codec port frame configuration and generator
// ----------------------------------------------------------------
module cpf_codec_port import cpf_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_port_global_enable,
  input wire logic i_sync_length_select,
  input wire logic i_serial_bit_clock,
  output logic o_frame_sync_out,
  output logic o_serial_data_out,
  output logic [2:0] o_mode,
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready
);
  // The alignment shift is worked out in 7 bits, which caps the width
  if (DATA_W < 32 || DATA_W > 127) begin : g_bad_width
    $error("cpf_codec_port: DATA_W must be 32 to 127 bits");
  end

  // Decodes both the slot length and data bit tables
  function automatic logic [5:0] len_decode(input logic [2:0] code);
    logic [5:0] len;
    len = CPF_CYC_32;
    unique case (code)
      3'h0: len = CPF_CYC_8;
      3'h1: len = CPF_CYC_16;
      3'h2: len = CPF_CYC_18;
      3'h3: len = CPF_CYC_20;
      3'h4: len = CPF_CYC_24;
      default: len = CPF_CYC_32;
    endcase
    return len;
  endfunction

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  logic [7:0] frame_config;
  logic [7:0] slot_format;
  logic cfg_write_ok;

  assign cfg_write_ok = i_reg_wr && !i_port_global_enable;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      frame_config <= CPF_FRAME_CONFIG_RESET;
      slot_format <= CPF_SLOT_FORMAT_RESET;
    end else if (cfg_write_ok) begin
      if (i_reg_addr == CPF_FRAME_CONFIG_ADDR) begin
        frame_config <= i_reg_wdata;
      end
      if (i_reg_addr == CPF_SLOT_FORMAT_ADDR) begin
        slot_format <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        CPF_FRAME_CONFIG_ADDR: o_reg_rdata <= frame_config;
        CPF_SLOT_FORMAT_ADDR: o_reg_rdata <= slot_format;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Decoded format
  // --------------------------------------------------------------
  logic [4:0] slot_count;
  cpf_mode_type mode;
  logic [5:0] common_len;
  logic [5:0] first_len;
  logic [5:0] audio_bits;
  logic secondary_slots;

  assign slot_count = frame_config[CPF_SLOT_COUNT_MSB:CPF_SLOT_COUNT_LSB];
  assign mode = cpf_mode_type'(frame_config[CPF_MODE_MSB:CPF_MODE_LSB]);
  assign common_len =
    len_decode(slot_format[CPF_COMMON_LEN_MSB:CPF_COMMON_LEN_LSB]);
  assign audio_bits = len_decode(slot_format[CPF_BITS_MSB:CPF_BITS_LSB]);
  // Only the AC97 modes carry the secondary address/data slots
  assign secondary_slots = (mode == CPF_MODE_AC97_GEN1) ||
                           (mode == CPF_MODE_AC97_GEN2);

  always_comb begin
    unique case (slot_format[CPF_FIRST_LEN_MSB:CPF_FIRST_LEN_LSB])
      CPF_FIRST_LEN_SAME: first_len = common_len;
      CPF_FIRST_LEN_8: first_len = CPF_CYC_8;
      CPF_FIRST_LEN_16: first_len = CPF_CYC_16;
      default: first_len = CPF_CYC_32;
    endcase
  end

  // I2S variants differ only in how the outside codecs are clocked;
  // the frame timing itself comes from the slot fields.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mode <= 3'h0;
    end else begin
      o_mode <= mode;
    end
  end

  // --------------------------------------------------------------
  // Serial bit clock edge detection
  // --------------------------------------------------------------
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic rise;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_meta <= i_serial_bit_clock;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  assign rise = sclk_sync && !sclk_prev;

  // --------------------------------------------------------------
  // Frame generator
  // --------------------------------------------------------------
  logic running;
  logic started;
  logic [4:0] slot_idx;
  logic [5:0] bit_cnt;
  logic [5:0] cur_len;
  logic [4:0] next_slot;
  logic [5:0] next_bit;
  logic next_audio;
  logic load;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic [DATA_W-1:0] shifter;
  logic [DATA_W-1:0] aligned;

  // A zero slot count gives no legal frame, so the generator idles
  assign running = i_port_global_enable && (slot_count != 5'h00);
  assign cur_len = (slot_idx == 5'h00) ? first_len : common_len;

  always_comb begin
    next_slot = slot_idx;
    next_bit = bit_cnt + 6'h01;
    if (!started) begin
      next_slot = 5'h00;
      next_bit = 6'h00;
    end else if (bit_cnt == cur_len - 6'h01) begin
      next_bit = 6'h00;
      next_slot = (slot_idx == slot_count) ? 5'h00 : slot_idx + 5'h01;
    end
  end

  assign next_audio = !(secondary_slots &&
                        (next_slot == CPF_SLOT_ADDR_IDX ||
                         next_slot == CPF_SLOT_DATA_IDX));
  assign load = rise && running && next_bit == 6'h00 && next_audio;
  // Sample sits in the low bits; move its MSB to the top of the word.
  // Secondary slots start from zero so the head sample is not leaked.
  assign aligned = (fifo_valid && next_audio) ?
    (fifo_data << (7'(DATA_W) - {1'b0, audio_bits})) : '0;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !running) begin
      started <= 1'b0;
      slot_idx <= 5'h00;
      bit_cnt <= 6'h00;
    end else if (rise) begin
      started <= 1'b1;
      slot_idx <= next_slot;
      bit_cnt <= next_bit;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !running) begin
      o_frame_sync_out <= 1'b0;
    end else if (rise) begin
      o_frame_sync_out <= (next_slot == 5'h00) &&
        (i_sync_length_select || next_bit == 6'h00);
    end
  end

  // Zeros shift in behind the sample, which pads the slot tail
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !running) begin
      shifter <= '0;
      o_serial_data_out <= 1'b0;
    end else if (rise) begin
      if (next_bit == 6'h00) begin
        o_serial_data_out <= aligned[DATA_W-1];
        shifter <= aligned << 1;
      end else begin
        o_serial_data_out <= shifter[DATA_W-1];
        shifter <= shifter << 1;
      end
    end
  end

  cpf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr_valid(i_tx_valid),
    .i_wr_data(i_tx_data),
    .o_wr_ready(o_tx_ready),
    .o_rd_valid(fifo_valid),
    .o_rd_data(fifo_data),
    .i_rd_ready(load)
  );

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic [10:0] frame_cnt;
  logic [10:0] frame_total;

  assign frame_total = 11'(first_len) + 11'(slot_count) * 11'(common_len);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !running) begin
      frame_cnt <= 11'h000;
    end else if (rise) begin
      frame_cnt <= (next_slot == 5'h00 && next_bit == 6'h00) ?
        11'h000 : frame_cnt + 11'h001;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_WR_LOCKED: assert property (
    i_port_global_enable |=> $stable(frame_config) && $stable(slot_format))
    else $error("config changed while port enabled");

  AST_WR_TAKEN: assert property (
    cfg_write_ok && i_reg_addr == CPF_FRAME_CONFIG_ADDR
    |=> frame_config == $past(i_reg_wdata))
    else $error("frame config write not taken");

  AST_SYNC_ONE: assert property (
    rise && started && running && !i_sync_length_select
    && slot_idx == 5'h00 && bit_cnt == 6'h00
    |=> !o_frame_sync_out until_with (rise && next_slot == 5'h00
    && next_bit == 6'h00))
    else $error("short frame sync longer than one cycle");

  AST_SYNC_SLOT0: assert property (
    o_frame_sync_out |-> slot_idx == 5'h00)
    else $error("frame sync outside slot 0");

  AST_SLOT0_LEN: assert property (
    rise && started && running && slot_idx == 5'h00
    && bit_cnt == first_len - 6'h01 |=> slot_idx == 5'h01)
    else $error("slot 0 length wrong");

  AST_COMMON_LEN: assert property (
    rise && started && running && slot_idx != 5'h00
    && bit_cnt < common_len - 6'h01 |=> $stable(slot_idx))
    else $error("slot ended early");

  AST_FRAME_LEN: assert property (
    rise && started && running && next_slot == 5'h00 && next_bit == 6'h00
    |-> frame_cnt == frame_total - 11'h001)
    else $error("frame length wrong");

  AST_PAD: assert property (
    rise && started && running && next_bit >= audio_bits
    |=> !o_serial_data_out)
    else $error("data beyond bits per slot");

  AST_SECONDARY: assert property (
    rise && running && !next_audio |-> !load ##1 !o_serial_data_out)
    else $error("sample data in secondary slot");
endmodule

// *** hdl/cpf_pkg.sv ***
package cpf_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [15:0] CPF_SLOT_FORMAT_ADDR = 16'hffdf;
  localparam logic [15:0] CPF_FRAME_CONFIG_ADDR = 16'hffe0;
  localparam logic [7:0] CPF_SLOT_FORMAT_RESET = 8'h00;
  localparam logic [7:0] CPF_FRAME_CONFIG_RESET = 8'h00;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int CPF_SLOT_COUNT_MSB = 7;
  localparam int CPF_SLOT_COUNT_LSB = 3;
  localparam int CPF_MODE_MSB = 2;
  localparam int CPF_MODE_LSB = 0;
  localparam int CPF_FIRST_LEN_MSB = 7;
  localparam int CPF_FIRST_LEN_LSB = 6;
  localparam int CPF_BITS_MSB = 5;
  localparam int CPF_BITS_LSB = 3;
  localparam int CPF_COMMON_LEN_MSB = 2;
  localparam int CPF_COMMON_LEN_LSB = 0;

  // --------------------------------------------------------------
  // Codes
  // --------------------------------------------------------------
  localparam logic [1:0] CPF_FIRST_LEN_SAME = 2'h0;
  localparam logic [1:0] CPF_FIRST_LEN_8 = 2'h1;
  localparam logic [1:0] CPF_FIRST_LEN_16 = 2'h2;
  localparam logic [5:0] CPF_CYC_8 = 6'h08;
  localparam logic [5:0] CPF_CYC_16 = 6'h10;
  localparam logic [5:0] CPF_CYC_18 = 6'h12;
  localparam logic [5:0] CPF_CYC_20 = 6'h14;
  localparam logic [5:0] CPF_CYC_24 = 6'h18;
  localparam logic [5:0] CPF_CYC_32 = 6'h20;
  localparam logic [4:0] CPF_SLOT_ADDR_IDX = 5'h01;
  localparam logic [4:0] CPF_SLOT_DATA_IDX = 5'h02;

  typedef enum logic [2:0] {
    CPF_MODE_GENERAL,
    CPF_MODE_COMPANION,
    CPF_MODE_AC97_GEN1,
    CPF_MODE_AC97_GEN2,
    CPF_MODE_I2S_SAME_FREQ,
    CPF_MODE_I2S_DIFF_FREQ,
    CPF_MODE_RSVD6,
    CPF_MODE_RSVD7
  } cpf_mode_type;

endpackage

// *** verif/cpf_codec_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far-side codec: serial clock source and frame listener
// ----------------------------------------------------------------
module cpf_codec_model (
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_sync,
  input wire logic i_data,
  output logic o_sclk
);
  logic sync_log [0:127];
  logic data_log [0:127];
  int cnt;

  // Clock stands low outside frames, 48 ns period while running
  always begin
    o_sclk = 1'b0;
    wait (i_run);
    // Offset keeps link edges clear of the system clock edges
    #1.25;
    while (i_run) begin
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
  end

  // Each rise logs the bit launched after the previous rise
  always @(posedge o_sclk or posedge i_clear) begin
    if (i_clear) begin
      cnt = 0;
    end else begin
      if (cnt > 0 && cnt < 129) begin
        sync_log[cnt-1] = i_sync;
        data_log[cnt-1] = i_data;
      end
      cnt = cnt + 1;
    end
  end
endmodule

// *** verif/cpf_codec_port_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module cpf_codec_port_tb_top import cpf_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b0;
  logic sel = 1'b0, sclk, sync, sdo, tx_valid = 1'b0, tx_ready, run = 1'b0;
  logic clr = 1'b0, rdy, exp_bit;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, got, w;
  logic [2:0] mode;
  logic [31:0] tx_data = 32'h0;
  int err_total = 0, n_tests = 0, cyc = 0, k, f, p, pos, sl;

  always #2.5 clk = ~clk;

  cpf_codec_port #(.DATA_W(32), .FIFO_DEPTH(8)) uut (.i_clk_sys(clk),
    .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_port_global_enable(en),
    .i_sync_length_select(sel), .i_serial_bit_clock(sclk),
    .o_frame_sync_out(sync), .o_serial_data_out(sdo), .o_mode(mode),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));

  cpf_codec_model codec (.i_run(run), .i_clear(clr), .i_sync(sync),
    .i_data(sdo), .o_sclk(sclk));

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    addr = a; wdata = d; wr = 1'b1;
    @(posedge clk); #1;
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk); #1;
    addr = a; rd = 1'b1;
    @(posedge clk); #1;
    rd = 1'b0;
    @(posedge clk); #1;
    d = rdata;
  endtask

  // Runs the link for 49 rises; the guard keeps a dead clock from hanging
  task automatic run_frames(input logic s);
    sel = s; clr = 1'b1;
    @(posedge clk); #1;
    clr = 1'b0; en = 1'b1; run = 1'b1;
    for (k = 0; k < 4000 && codec.cnt < 49; k++) @(posedge clk);
    run = 1'b0;
    @(posedge clk); #1;
    en = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("idle sync", 1'b0, sync)
  endtask

  // Fill the buffer with 0xa0 upwards until it refuses
  task automatic fill_fifo;
    k = 0;
    tx_valid = 1'b1;
    tx_data = 32'ha0;
    repeat (12) begin
      rdy = tx_ready;
      @(posedge clk); #1;
      if (rdy === 1'b1) begin
        k++;
        tx_data = 32'ha0 + k;
      end
    end
    tx_valid = 1'b0;
    `CHK("fifo fill", 8, k)
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Hang guard: frame runs need about 470 cycles each
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    reg_rd(CPF_SLOT_FORMAT_ADDR, got);
    `CHK("fmt reset", CPF_SLOT_FORMAT_RESET, got)
    reg_rd(CPF_FRAME_CONFIG_ADDR, got);
    `CHK("cfg reset", CPF_FRAME_CONFIG_RESET, got)
    reg_rd(16'h1234, got);
    `CHK("unmapped", 8'h00, got)
    $display("test reset done");
    // Every defined mode; reserved codes are left alone
    for (int m = 0; m < 6; m++) begin
      w = {5'h01, m[2:0]};
      reg_wr(CPF_FRAME_CONFIG_ADDR, w);
      reg_rd(CPF_FRAME_CONFIG_ADDR, got);
      `CHK("cfg rb", w, got)
      `CHK("mode", m[2:0], mode)
    end
    $display("test modes done");
    // Two slots, general mode; slot 0 of 8, others 16, 8 data bits
    reg_wr(CPF_FRAME_CONFIG_ADDR, 8'h08);
    reg_wr(CPF_SLOT_FORMAT_ADDR, 8'h41);
    en = 1'b1;
    reg_wr(CPF_FRAME_CONFIG_ADDR, 8'h13);
    reg_rd(CPF_FRAME_CONFIG_ADDR, got);
    `CHK("locked", 8'h08, got)
    en = 1'b0;
    $display("test lock done");
    fill_fifo();
    run_frames(1'b0);
    `CHK("ready back", 1'b1, tx_ready)
    for (int b = 0; b < 48; b++) begin
      f = b / 24;
      p = b % 24;
      pos = (p < 8) ? p : p - 8;
      w = 8'ha0 + 8'(2 * f + ((p >= 8) ? 1 : 0));
      `CHK("sync 1bit", (p == 0), codec.sync_log[b])
      `CHK("data", (pos < 8) ? w[7-pos] : 1'b0, codec.data_log[b])
    end
    $display("test frame short sync done");
    run_frames(1'b1);
    for (int b = 0; b < 48; b++) begin
      `CHK("sync long", ((b % 24) < 8), codec.sync_log[b])
    end
    $display("test frame long sync done");
    // AC97 first generation, four slots; slot 0 of 16, others 8
    reg_wr(CPF_FRAME_CONFIG_ADDR, 8'h1a);
    reg_wr(CPF_SLOT_FORMAT_ADDR, 8'h80);
    fill_fifo();
    run_frames(1'b0);
    for (int b = 0; b < 48; b++) begin
      f = b / 40;
      p = b % 40;
      sl = (p < 16) ? 0 : 1 + (p - 16) / 8;
      pos = (p < 16) ? p : (p - 16) % 8;
      w = 8'ha0 + 8'(2 * f + ((sl == 3) ? 1 : 0));
      exp_bit = (sl % 3 == 0 && pos < 8) ? w[7-pos] : 1'b0;
      `CHK("sync ac97", (p == 0), codec.sync_log[b])
      `CHK("data ac97", exp_bit, codec.data_log[b])
    end
    $display("test ac97 secondary slots done");
    summarize();
  end
endmodule
